//--- core/rdom_timer.sv
// Reset timeout counter in monitoring sample periods
`timescale 1ns/10ps
`default_nettype none
`include "rdom_params.svh"
module rdom_timer #(
  parameter int unsigned UNIT_CYCLES = `RDOM_SAMPLE_UNIT_CYCLES
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  rdom_if.tmr       tif
);
  logic [15:0] unit_cnt_reg;
  logic [15:0] unit_cnt_next;
  logic [7:0]  samp_cnt_reg;
  logic [7:0]  samp_cnt_next;
  logic [15:0] to_cnt_reg;
  logic [15:0] to_cnt_next;
  logic [7:0]  period_eff;

  always_comb
  begin
    period_eff    = (tif.period == 8'h00) ? 8'h01 : tif.period;
    unit_cnt_next = unit_cnt_reg;
    samp_cnt_next = samp_cnt_reg;
    to_cnt_next   = to_cnt_reg;
    if (!tif.run)
    begin
      // Restart from zero whenever regulation is lost
      unit_cnt_next = 16'h0000; // RULE15
      samp_cnt_next = 8'h00;
      to_cnt_next   = 16'h0000;
    end
    else if (unit_cnt_reg == 16'(UNIT_CYCLES - 1))
    begin
      unit_cnt_next = 16'h0000;
      if (samp_cnt_reg == period_eff - 8'h01)
      begin
        samp_cnt_next = 8'h00;
        // One step per sample period
        if (to_cnt_reg != 16'hffff)
          to_cnt_next = to_cnt_reg + 16'h0001; // RULE2
      end
      else
        samp_cnt_next = samp_cnt_reg + 8'h01;
    end
    else
      unit_cnt_next = unit_cnt_reg + 16'h0001;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      unit_cnt_reg <= 16'h0000;
      samp_cnt_reg <= 8'h00;
      to_cnt_reg   <= 16'h0000;
    end
    else
    begin
      unit_cnt_reg <= unit_cnt_next;
      samp_cnt_reg <= samp_cnt_next;
      to_cnt_reg   <= to_cnt_next;
    end
  end

  assign tif.expired = tif.run && (to_cnt_reg >= tif.delay); // RULE1

endmodule : rdom_timer
`default_nettype wire

//--- core/rdom_top.sv
// Reset timeout and per-output mode configuration of a supply manager
`timescale 1ns/10ps
`default_nettype none
`include "rdom_params.svh"

// Notes on behaviour
// RULE1 - Reset released only after delay times sample period times 100 us.
// RULE2 - Timeout advances in whole monitoring sample periods.
// RULE3 - Reset delay is a 16-bit value, zero after power-up.
// RULE4 - Mode bit 5 opens DAC switch when reference-mode supply is off.
// RULE5 - Mode bit 4 spreads this output's fault to all outputs.
// RULE6 - Mode bit 3 picks 5.5 V sense range, else 2.0 V.
// RULE7 - Voltage commands scaled by range in force when received.
// RULE8 - Host sets input range before any voltage command.
// RULE9 - Host should not change range while the supply is on.
// RULE10 - Mode bit 2 set makes enable on-state low, clear makes it high.
// RULE11 - Mode bit 1 picks feedback mode, else reference-input mode.
// RULE12 - Mode bit 0 set excludes this output from page 255 writes.
// RULE13 - Reset is active-low open drain, low during power-on.
// RULE14 - Reset drops again if the selected supply is disabled.
// RULE15 - Timeout counts while regulated, restarts when regulation lost.
module rdom_top #(
  parameter int unsigned NUM_CH      = 4,
  parameter int unsigned UNIT_CYCLES = `RDOM_SAMPLE_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset,
  // Command port
  input  wire logic                     i_cmd_valid,
  input  wire logic                     i_cmd_write,
  input  wire logic [7:0]               i_cmd_code,
  input  wire logic [15:0]              i_cmd_data,
  input  wire logic [7:0]               i_page,
  output logic                          o_rd_valid,
  output logic [15:0]                   o_rd_data,
  // Settings held elsewhere
  input  wire logic [7:0]               i_monitor_sample_period,
  input  wire logic [7:0]               i_reset_source_select,
  // Channel status
  input  wire logic                     i_powering_on,
  input  wire logic [NUM_CH-1:0]        i_enable_req,
  input  wire logic [NUM_CH-1:0]        i_in_regulation,
  input  wire logic [NUM_CH-1:0]        i_fault,
  // Channel controls
  output logic [NUM_CH-1:0]             o_supply_enable_out,
  output logic [NUM_CH-1:0]             o_dac_switch_closed,
  output logic [NUM_CH-1:0]             o_feedback_mode,
  output logic [NUM_CH-1:0]             o_range_high,
  output logic [NUM_CH-1:0]             o_fault_eff,
  output rdom_pkg::rdom_code_t [NUM_CH-1:0] o_vout_code,
  // Open-drain reset pin
  output logic                          o_reset_out,
  output logic                          o_reset_oe
);
  import rdom_pkg::*;

  // Channel mask addressed by a write on a page
  function automatic logic [NUM_CH-1:0] page_targets(
    input logic [7:0]       page,
    input rdom_mode_t [NUM_CH-1:0] modes
  );
    logic [NUM_CH-1:0] m;
    m = '0;
    if (page == `RDOM_PAGE_ALL)
    begin
      for (int i = 0; i < NUM_CH; i++)
        m[i] = ~modes[i][`RDOM_BIT_PAGE_SKIP]; // RULE12
    end
    else if (page < 8'(NUM_CH))
      m[page[$clog2(NUM_CH)-1:0]] = 1'b1;
    return m;
  endfunction : page_targets

  // Millivolts to DAC code for the range in force
  function automatic rdom_code_t mv_to_code(
    input logic [15:0] mv,
    input logic        range_high
  );
    logic [27:0] prod;
    logic [27:0] q;
    prod = 28'(mv) * 28'(`RDOM_CODE_MAX);
    if (range_high)
      q = prod / 28'(`RDOM_FS_HIGH_MV); // RULE6
    else
      q = prod / 28'(`RDOM_FS_LOW_MV);
    if (q > 28'(`RDOM_CODE_MAX))
      q = 28'(`RDOM_CODE_MAX);
    return q[11:0];
  endfunction : mv_to_code

  rdom_if tif ();

  // Register file state
  logic [15:0]              delay_reg;
  logic [15:0]              delay_next;
  rdom_mode_t [NUM_CH-1:0]  mode_reg;
  rdom_mode_t [NUM_CH-1:0]  mode_next;
  rdom_code_t [NUM_CH-1:0]  vout_reg;
  rdom_code_t [NUM_CH-1:0]  vout_next;
  logic                     rd_valid_reg;
  logic                     rd_valid_next;
  logic [15:0]              rd_data_reg;
  logic [15:0]              rd_data_next;
  logic [NUM_CH-1:0]        tgt;
  logic [1:0]               rd_ch;

  always_comb
  begin
    delay_next    = delay_reg;
    mode_next     = mode_reg;
    vout_next     = vout_reg;
    rd_valid_next = 1'b0;
    rd_data_next  = rd_data_reg;
    tgt           = page_targets(i_page, mode_reg);
    rd_ch         = (i_page < 8'(NUM_CH)) ? i_page[1:0] : 2'b00;
    if (i_cmd_valid && i_cmd_write)
    begin
      if (i_cmd_code == `RDOM_CMD_RESET_DELAY)
        delay_next = i_cmd_data; // RULE3
      else if (i_cmd_code == `RDOM_CMD_OUTPUT_MODE)
      begin
        for (int i = 0; i < NUM_CH; i++)
          if (tgt[i])
            mode_next[i] = {2'b00, i_cmd_data[5:0]};
      end
      else if (i_cmd_code == `RDOM_CMD_VOUT)
      begin
        // Scaled once on receipt, never rescaled later
        for (int i = 0; i < NUM_CH; i++)
          if (tgt[i])
            vout_next[i] = mv_to_code(i_cmd_data,
              mode_reg[i][`RDOM_BIT_RANGE_HIGH]); // RULE7 RULE8
      end
    end
    else if (i_cmd_valid)
    begin
      rd_valid_next = 1'b1;
      if (i_cmd_code == `RDOM_CMD_RESET_DELAY)
        rd_data_next = delay_reg;
      else if (i_cmd_code == `RDOM_CMD_OUTPUT_MODE)
        rd_data_next = {8'h00, mode_reg[rd_ch]};
      else if (i_cmd_code == `RDOM_CMD_VOUT)
        rd_data_next = {4'h0, vout_reg[rd_ch]};
      else
        rd_data_next = 16'h0000;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      delay_reg    <= `RDOM_DELAY_RESET; // RULE3
      mode_reg     <= {NUM_CH{`RDOM_MODE_RESET}};
      vout_reg     <= '0;
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= 16'h0000;
    end
    else
    begin
      delay_reg    <= delay_next;
      mode_reg     <= mode_next;
      vout_reg     <= vout_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  // Channel control state
  logic [NUM_CH-1:0] fault_eff_next;
  logic [NUM_CH-1:0] fault_eff_reg;
  logic [NUM_CH-1:0] on_state;
  logic [NUM_CH-1:0] en_out_next;
  logic [NUM_CH-1:0] en_out_reg;
  logic [NUM_CH-1:0] dac_closed_next;
  logic [NUM_CH-1:0] dac_closed_reg;
  logic [NUM_CH-1:0] fb_next;
  logic [NUM_CH-1:0] fb_reg;
  logic [NUM_CH-1:0] range_next;
  logic [NUM_CH-1:0] range_reg;
  logic              fault_spread;

  always_comb
  begin
    fault_spread = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
      fault_spread = fault_spread |
        (i_fault[i] & mode_reg[i][`RDOM_BIT_FAULT_ALL]); // RULE5
    for (int i = 0; i < NUM_CH; i++)
    begin
      fault_eff_next[i]  = i_fault[i] | fault_spread; // RULE5
      on_state[i]        = i_enable_req[i] & ~fault_eff_next[i];
      en_out_next[i]     = mode_reg[i][`RDOM_BIT_EN_POL_LOW] ?
                           ~on_state[i] : on_state[i]; // RULE10
      fb_next[i]         = mode_reg[i][`RDOM_BIT_FB_MODE]; // RULE11
      range_next[i]      = mode_reg[i][`RDOM_BIT_RANGE_HIGH]; // RULE6
      dac_closed_next[i] = ~(mode_reg[i][`RDOM_BIT_DAC_OPEN] &
                           ~fb_next[i] & ~on_state[i]); // RULE4
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      fault_eff_reg  <= '0;
      en_out_reg     <= '0;
      dac_closed_reg <= '1;
      fb_reg         <= '0;
      range_reg      <= '0;
    end
    else
    begin
      fault_eff_reg  <= fault_eff_next;
      en_out_reg     <= en_out_next;
      dac_closed_reg <= dac_closed_next;
      fb_reg         <= fb_next;
      range_reg      <= range_next;
    end
  end

  // Reset output sequencing
  rdom_state_t       rst_state_reg;
  rdom_state_t       rst_state_next;
  logic              rst_oe_reg;
  logic              rst_oe_next;
  logic              sel_valid;
  logic              sel_good;
  logic [1:0]        sel;

  always_comb
  begin
    sel       = i_reset_source_select[1:0];
    sel_valid = (i_reset_source_select < 8'(NUM_CH));
    // Selected supply on, fault free and in regulation
    sel_good  = sel_valid && !i_powering_on && on_state[sel] &&
                i_in_regulation[sel]; // RULE14
    tif.delay  = delay_reg;
    tif.period = i_monitor_sample_period;
    tif.run    = (rst_state_reg == RDOM_TIMING) && sel_good; // RULE15
    rst_state_next = rst_state_reg;
    case (rst_state_reg)
      RDOM_HOLD:
        if (sel_good)
          rst_state_next = RDOM_TIMING;
      RDOM_TIMING:
        if (!sel_good)
          rst_state_next = RDOM_HOLD; // RULE15
        else if (tif.expired)
          rst_state_next = RDOM_RELEASED; // RULE1
      RDOM_RELEASED:
        if (!sel_good)
          rst_state_next = RDOM_HOLD; // RULE14
      default:
        rst_state_next = RDOM_HOLD;
    endcase
    rst_oe_next = (rst_state_next != RDOM_RELEASED); // RULE13
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      rst_state_reg <= RDOM_HOLD;
      rst_oe_reg    <= 1'b1; // RULE13
    end
    else
    begin
      rst_state_reg <= rst_state_next;
      rst_oe_reg    <= rst_oe_next;
    end
  end

  rdom_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .tif       (tif.tmr)
  );

  // Open drain pin only ever pulls low
  assign o_reset_out         = 1'b0;
  assign o_reset_oe          = rst_oe_reg;
  assign o_rd_valid          = rd_valid_reg;
  assign o_rd_data           = rd_data_reg;
  assign o_supply_enable_out = en_out_reg;
  assign o_dac_switch_closed = dac_closed_reg;
  assign o_feedback_mode     = fb_reg;
  assign o_range_high        = range_reg;
  assign o_fault_eff         = fault_eff_reg;
  assign o_vout_code         = vout_reg;

endmodule : rdom_top
`default_nettype wire

//--- shared/rdom_if.sv
// Link between the control logic and the reset timeout timer
`timescale 1ns/10ps
`default_nettype none
interface rdom_if;
  logic [15:0] delay;
  logic [7:0]  period;
  logic        run;
  logic        expired;
  modport ctl (output delay, output period, output run, input expired);
  modport tmr (input delay, input period, input run, output expired);
endinterface : rdom_if
`default_nettype wire

//--- shared/rdom_params.svh
// Constants for the reset delay and output mode block
`ifndef RDOM_PARAMS_SVH
`define RDOM_PARAMS_SVH

`define RDOM_CMD_RESET_DELAY   8'hdd
`define RDOM_CMD_OUTPUT_MODE   8'hde
`define RDOM_CMD_VOUT          8'h21
`define RDOM_PAGE_ALL          8'hff

`define RDOM_DELAY_RESET       16'h0000
`define RDOM_MODE_RESET        8'h00

`define RDOM_BIT_DAC_OPEN      5
`define RDOM_BIT_FAULT_ALL     4
`define RDOM_BIT_RANGE_HIGH    3
`define RDOM_BIT_EN_POL_LOW    2
`define RDOM_BIT_FB_MODE       1
`define RDOM_BIT_PAGE_SKIP     0

`define RDOM_FS_LOW_MV         2000
`define RDOM_FS_HIGH_MV        5500
`define RDOM_CODE_MAX          4095

`define RDOM_CLK_PERIOD_NS     50
`define RDOM_SAMPLE_UNIT_NS    100000
`define RDOM_SAMPLE_UNIT_CYCLES (`RDOM_SAMPLE_UNIT_NS / `RDOM_CLK_PERIOD_NS)

`endif

//--- shared/rdom_pkg.sv
// Types for the reset delay and output mode block
package rdom_pkg;
  typedef logic [7:0]  rdom_mode_t;
  typedef logic [11:0] rdom_code_t;
  typedef enum logic [1:0] {RDOM_HOLD, RDOM_TIMING, RDOM_RELEASED} rdom_state_t;
endpackage : rdom_pkg

//--- verif/rdom_supply_model.sv
// Behavioural model of four supplies answering their enable pins
`timescale 1ns/10ps
`default_nettype none
module rdom_supply_model (
  // Clock
  input  wire logic       i_clk,
  // Enable pins and test controls
  input  wire logic [3:0] i_en_pin,
  input  wire logic [3:0] i_pol_low,
  input  wire logic [3:0] i_sag,
  // Power-good back to the block
  output logic      [3:0] o_in_reg
);
  logic [1:0] ramp [4] = '{default: 2'h0};
  // Output settles three cycles after the pin turns it on
  always @(posedge i_clk)
    for (int k = 0; k < 4; k++)
      ramp[k] <= (i_en_pin[k] === i_pol_low[k]) ? 2'h0 :
                 (ramp[k] == 2'h3) ? 2'h3 : ramp[k] + 2'h1;
  always_comb
    for (int k = 0; k < 4; k++)
      o_in_reg[k] = (ramp[k] == 2'h3) && !i_sag[k];
endmodule : rdom_supply_model
`default_nettype wire

//--- verif/rdom_top_sva.sv
// Checker for the reset delay and output mode block
`timescale 1ns/10ps
`default_nettype none
`include "rdom_params.svh"
module rdom_top_sva #(
  parameter int unsigned NUM_CH      = 4,
  parameter int unsigned UNIT_CYCLES = `RDOM_SAMPLE_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic              i_clk_sys,
  input wire logic              i_reset,
  // Command port
  input wire logic              i_cmd_valid,
  input wire logic              i_cmd_write,
  input wire logic [7:0]        i_cmd_code,
  input wire logic [15:0]       i_cmd_data,
  input wire logic [7:0]        i_page,
  input wire logic              o_rd_valid,
  // Status and results
  input wire logic [7:0]        i_monitor_sample_period,
  input wire logic [7:0]        i_reset_source_select,
  input wire logic              i_powering_on,
  input wire logic [NUM_CH-1:0] i_enable_req,
  input wire logic [NUM_CH-1:0] i_in_regulation,
  input wire logic [NUM_CH-1:0] i_fault,
  input wire logic [NUM_CH-1:0] o_fault_eff,
  input wire logic              o_reset_out,
  input wire logic              o_reset_oe
);
  logic [15:0] dly_reg, dly_next;
  int unsigned run_reg, run_next, tmo;
  logic        sel_ok, rd_cmd;
  logic [1:0]  s;
  // Shadow of the delay setting and of the time spent in regulation
  always_comb
  begin
    s = i_reset_source_select[1:0];
    sel_ok = i_reset_source_select < 8'h04;
    rd_cmd = i_cmd_valid && !i_cmd_write;
    tmo = dly_reg * UNIT_CYCLES * ((i_monitor_sample_period == 8'h00) ?
          1 : i_monitor_sample_period);
    dly_next = dly_reg;
    // One shared delay setting, taken on any page
    if (i_cmd_valid && i_cmd_write && i_cmd_code == `RDOM_CMD_RESET_DELAY)
      dly_next = i_cmd_data;
    run_next = (sel_ok && i_enable_req[s] && i_in_regulation[s]
                && !i_powering_on) ? run_reg + 1 : 0;
    if (i_reset)
    begin
      dly_next = 16'h0;
      run_next = 0;
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    dly_reg <= dly_next;
    run_reg <= run_next;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  rst_state_a:
    assert property (disable iff (1'b0) $fell(i_reset) |->
      o_reset_oe && !o_rd_valid) else $error("bad state after reset");
  pin_low_a:
    assert property (o_reset_out == 1'b0) else $error("reset data not low");
  pwr_hold_a:
    assert property (i_powering_on |=> o_reset_oe)
    else $error("reset released while powering on");
  sel_off_a:
    assert property (!sel_ok || !i_enable_req[s] |=> o_reset_oe)
    else $error("reset released with source off");
  early_rel_a:
    assert property ($fell(o_reset_oe) |-> run_reg >= tmo)
    else $error("reset released too early");
  rd_pulse_a:
    assert property (o_rd_valid == $past(rd_cmd))
    else $error("read answer pulse wrong");
  own_fault_a:
    assert property (|i_fault |=> (o_fault_eff & $past(i_fault)) ==
      $past(i_fault)) else $error("own fault not seen");
  no_fault_a:
    assert property (|o_fault_eff |-> |$past(i_fault))
    else $error("fault without cause");
  rel_c: cover property ($fell(o_reset_oe));
  gfl_c: cover property (&o_fault_eff);
  rd_c: cover property (o_rd_valid);
endmodule : rdom_top_sva
bind rdom_top rdom_top_sva #(.NUM_CH(NUM_CH), .UNIT_CYCLES(UNIT_CYCLES))
  i_sva (.i_clk_sys, .i_reset, .i_cmd_valid, .i_cmd_write, .i_cmd_code,
  .i_cmd_data, .i_page, .o_rd_valid, .i_monitor_sample_period,
  .i_reset_source_select, .i_powering_on, .i_enable_req, .i_in_regulation,
  .i_fault, .o_fault_eff, .o_reset_out, .o_reset_oe);
`default_nettype wire

//--- verif/rdom_top_tb_top.sv
// Self-checking testbench of the reset delay and output mode block
`timescale 1ns/10ps
`default_nettype none
`include "rdom_params.svh"
module rdom_top_tb_top;
  import rdom_pkg::*;
  localparam int UC = 4;
  localparam int T = 3 * 2 * UC;
  localparam logic [7:0] DL = `RDOM_CMD_RESET_DELAY;
  localparam logic [7:0] MD = `RDOM_CMD_OUTPUT_MODE;
  localparam logic [7:0] VO = `RDOM_CMD_VOUT;
  logic i_clk_sys, i_reset, i_cmd_valid, i_cmd_write, i_powering_on, rv;
  logic o_rd_valid, o_reset_out, o_reset_oe;
  logic [7:0] i_cmd_code, i_page, i_monitor_sample_period;
  logic [7:0] i_reset_source_select;
  logic [15:0] i_cmd_data, o_rd_data, rdat;
  logic [3:0] i_enable_req, i_in_regulation, i_fault, i_sag, o_fault_eff;
  logic [3:0] o_supply_enable_out, o_dac_switch_closed, o_feedback_mode;
  logic [3:0] o_range_high;
  rdom_code_t [3:0] o_vout_code;
  int err_count, cmp_count, cyc;
  rdom_top #(.UNIT_CYCLES(UC)) i_dut (.i_clk_sys, .i_reset, .i_cmd_valid,
    .i_cmd_write, .i_cmd_code, .i_cmd_data, .i_page, .o_rd_valid, .o_rd_data,
    .i_monitor_sample_period, .i_reset_source_select, .i_powering_on,
    .i_enable_req, .i_in_regulation, .i_fault, .o_supply_enable_out,
    .o_dac_switch_closed, .o_feedback_mode, .o_range_high, .o_fault_eff,
    .o_vout_code, .o_reset_out, .o_reset_oe);
  rdom_supply_model i_sup (.i_clk(i_clk_sys), .i_en_pin(o_supply_enable_out),
    .i_pol_low(4'h1), .i_sag(i_sag), .o_in_reg(i_in_regulation));
  initial
  begin
    i_clk_sys = 0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      report_and_stop;
    end
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  // One command, then one idle cycle; captures any read answer
  task automatic cmd(input logic w, input logic [7:0] c, p,
                     input logic [15:0] d);
    {i_cmd_valid, i_cmd_write, i_cmd_code, i_page, i_cmd_data} =
      {1'b1, w, c, p, d};
    tick(1);
    i_cmd_valid = 0;
    rv = o_rd_valid;
    rdat = o_rd_data;
    chk("rdv", rv, !w);
    tick(1);
  endtask : cmd
  task automatic rd(input logic [7:0] c, p, input logic [15:0] e);
    cmd(0, c, p, 16'h0);
    chk("rd", rdat, e);
  endtask : rd
  task automatic wait_rel(output int n);
    n = 0;
    while (o_reset_oe !== 1'b0 && n < 200)
    begin
      tick(1);
      n++;
    end
  endtask : wait_rel
  task automatic t_reset;
    chk("oe", o_reset_oe, 1);
    chk("rst", o_reset_out, 0);
    chk("dac", o_dac_switch_closed, 4'hf);
    rd(DL, 8'h00, 16'h0);
    rd(MD, 8'h00, 16'h0);
  endtask : t_reset
  task automatic t_modes;
    cmd(1, MD, 8'h00, 16'h04);
    cmd(1, MD, 8'h01, 16'h02);
    cmd(1, MD, 8'h02, 16'h08);
    cmd(1, MD, 8'h03, 16'h20);
    chk("fbm", o_feedback_mode, 4'h2);
    chk("rng", o_range_high, 4'h4);
    chk("eno", o_supply_enable_out, 4'h1);
    chk("dac", o_dac_switch_closed, 4'h7);
    i_enable_req = 4'hf;
    tick(2);
    chk("eno", o_supply_enable_out, 4'he);
    chk("dac", o_dac_switch_closed, 4'hf);
    i_enable_req = 4'h0;
    tick(2);
  endtask : t_modes
  task automatic t_volt;
    cmd(1, VO, 8'h02, 16'd5500);
    cmd(1, VO, 8'h01, 16'd1000);
    chk("v2", o_vout_code[2], 16'hfff);
    chk("v1", o_vout_code[1], 16'h7ff);
    cmd(1, MD, 8'h01, 16'h0a);
    chk("v1", o_vout_code[1], 16'h7ff);
    cmd(1, VO, 8'h01, 16'd4000);
    chk("v1", o_vout_code[1], 16'hba2);
  endtask : t_volt
  task automatic t_bcast;
    cmd(1, MD, 8'h00, 16'h05);
    cmd(1, MD, 8'hff, 16'h02);
    cmd(1, MD, 8'h05, 16'h3f);
    chk("fbm", o_feedback_mode, 4'he);
    chk("rng", o_range_high, 4'h0);
    rd(MD, 8'h00, 16'h05);
  endtask : t_bcast
  task automatic t_fault;
    cmd(1, MD, 8'h01, 16'h12);
    i_fault = 4'h2;
    tick(2);
    chk("gfl", o_fault_eff, 4'hf);
    i_fault = 4'h4;
    tick(2);
    chk("gfl", o_fault_eff, 4'h4);
    i_fault = 4'h0;
    tick(2);
  endtask : t_fault
  task automatic t_seq;
    int n;
    cmd(1, DL, 8'h00, 16'h0003);
    rd(DL, 8'h02, 16'h0003);
    i_reset_source_select = 8'h01;
    i_powering_on = 1;
    i_enable_req = 4'h2;
    tick(20);
    chk("oe", o_reset_oe, 1);
    i_powering_on = 0;
    wait_rel(n);
    chk("tmo", 16'(n), 16'(T + 2));
    i_sag = 4'h2;
    tick(2);
    chk("oe", o_reset_oe, 1);
    i_sag = 4'h0;
    tick(10);
    chk("oe", o_reset_oe, 1);
    // Drop regulation in mid count; the count starts over
    i_sag = 4'h2;
    tick(1);
    i_sag = 4'h0;
    wait_rel(n);
    chk("tmo", 16'(n), 16'(T + 2));
    i_fault = 4'h2;
    tick(4);
    chk("oe", o_reset_oe, 1);
    i_fault = 4'h0;
    wait_rel(n);
    chk("rel", o_reset_oe, 0);
    i_enable_req = 4'h0;
    tick(3);
    chk("oe", o_reset_oe, 1);
    i_reset_source_select = 8'h04;
    i_enable_req = 4'h2;
    tick(T + 10);
    chk("oe", o_reset_oe, 1);
  endtask : t_seq
  task automatic report_and_stop;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {i_reset, i_cmd_valid, i_cmd_write, i_powering_on} = 4'h8;
    {i_cmd_code, i_page, i_cmd_data} = 32'h0;
    {i_enable_req, i_fault, i_sag} = 12'h0;
    i_monitor_sample_period = 8'h02;
    i_reset_source_select = 8'h07;
    tick(6);
    i_reset = 0;
    t_reset;
    t_modes;
    t_volt;
    t_bcast;
    t_fault;
    t_seq;
    report_and_stop;
  end
endmodule : rdom_top_tb_top
`default_nettype wire
